// ### src/isc_config.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Receive buffer guard bit 9, resets one
// - Bit 8 selects length or data first, in CBC-MAC mode only
// - Three key selects, resets 1,1,0
// - Tag length code (M-2)/2, resets 1
// - Mode: off, CBC-MAC, CTR, CCM
// - Transmit prefix meaning depends on mode
// - Receive prefix meaning depends on mode
module isc_config (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Frame context from the datapath
  input  wire logic [7:0]  frame_len,
  input  wire logic        dir_is_tx,
  input  wire logic        op_standalone,
  // Decoded configuration
  output logic             rx_buffer_guard,
  output isc_pkg::isc_mode_t inline_cipher_mode,
  output logic             sec_enabled,
  output logic             mode_cbcmac,
  output logic             mode_ctr,
  output logic             mode_ccm,
  output logic             key_select,
  output logic             standalone_key_choice,
  output logic             transmit_key_choice,
  output logic             receive_key_choice,
  output logic      [4:0]  tag_bytes,
  output logic             tag_code_bad,
  output logic      [6:0]  cipher_skip_len,
  output logic      [6:0]  auth_skip_len,
  output logic      [6:0]  auth_only_len,
  output logic             mac_first_is_len,
  output logic      [7:0]  mac_first_len
);

  // ******************************
  // Helper functions
  // ******************************
  // Address match against one entry of the register map
  function automatic logic addr_is(
    input logic [5:0] addr,
    input logic [5:0] target
  );
    return (addr == target);
  endfunction : addr_is

  // Writable bits only; reserved bits are forced to zero
  function automatic logic [15:0] keep_writable(
    input logic [15:0] data,
    input logic [15:0] wmask
  );
    return (data & wmask);
  endfunction : keep_writable

  // Seven-bit length field starting at a given bit
  function automatic logic [6:0] field7(
    input logic [15:0] word,
    input int          lsb
  );
    return word[lsb +: 7];
  endfunction : field7

  // Mode field compare
  function automatic logic mode_is(
    input logic [1:0]         code,
    input isc_pkg::isc_mode_t mode
  );
    return (isc_pkg::isc_mode_t'(code) == mode);
  endfunction : mode_is

  // Prefix length when its mode is active, zero otherwise
  function automatic logic [6:0] gate_prefix(
    input logic       active,
    input logic [6:0] len
  );
    return active ? len : 7'h00;
  endfunction : gate_prefix

  // ******************************
  // Write decode
  // ******************************
  logic        wr_primary;
  logic        wr_length;
  logic [15:0] primary_wdata;
  logic [15:0] length_wdata;

  assign wr_primary    = reg_wr && addr_is(reg_addr, isc_pkg::ADDR_SEC_PRIMARY);
  assign wr_length     = reg_wr && addr_is(reg_addr, isc_pkg::ADDR_SEC_LENGTH);
  assign primary_wdata = keep_writable(reg_wdata, isc_pkg::PRIMARY_WMASK);
  assign length_wdata  = keep_writable(reg_wdata, isc_pkg::LENGTH_WMASK);

  // ******************************
  // Registers
  // ******************************
  logic [15:0] primary_q;
  logic [15:0] primary_d;
  logic [15:0] length_q;
  logic [15:0] length_d;

  // Reserved bits are dropped; they read back as zero
  assign primary_d = wr_primary ? primary_wdata : primary_q;
  assign length_d  = wr_length  ? length_wdata  : length_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      primary_q <= isc_pkg::PRIMARY_RESET;
    end else begin
      primary_q <= primary_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      length_q <= isc_pkg::LENGTH_RESET;
    end else begin
      length_q <= length_d;
    end
  end

  // ******************************
  // Read back
  // ******************************
  logic        rd_primary;
  logic        rd_length;

  assign rd_primary = addr_is(reg_addr, isc_pkg::ADDR_SEC_PRIMARY);
  assign rd_length  = addr_is(reg_addr, isc_pkg::ADDR_SEC_LENGTH);
  assign reg_rdata  = rd_primary ? primary_q :
                      rd_length  ? length_q  : 16'h0000;

  // ******************************
  // Register fields
  // ******************************
  logic        guard_bit;
  logic        len_first_bit;
  logic        sakey_bit;
  logic        txkey_bit;
  logic        rxkey_bit;
  logic [2:0]  tag_code;
  logic [1:0]  mode_code;
  logic [6:0]  tx_prefix;
  logic [6:0]  rx_prefix;

  assign guard_bit     = primary_q[isc_pkg::GUARD_BIT];
  assign len_first_bit = primary_q[isc_pkg::HEAD_BIT];
  assign sakey_bit     = primary_q[isc_pkg::SAKEY_BIT];
  assign txkey_bit     = primary_q[isc_pkg::TXKEY_BIT];
  assign rxkey_bit     = primary_q[isc_pkg::RXKEY_BIT];
  assign tag_code      = primary_q[isc_pkg::TAG_LSB +: 3];
  assign mode_code     = primary_q[isc_pkg::MODE_LSB +: 2];
  assign tx_prefix     = field7(length_q, isc_pkg::TXL_LSB);
  assign rx_prefix     = field7(length_q, isc_pkg::RXL_LSB);

  // ******************************
  // Mode decode
  // ******************************
  assign inline_cipher_mode = isc_pkg::isc_mode_t'(mode_code);
  assign sec_enabled        = !mode_is(mode_code, isc_pkg::ISC_MODE_OFF);
  assign mode_cbcmac        = mode_is(mode_code, isc_pkg::ISC_MODE_CBCMAC);
  assign mode_ctr           = mode_is(mode_code, isc_pkg::ISC_MODE_CTR);
  assign mode_ccm           = mode_is(mode_code, isc_pkg::ISC_MODE_CCM);

  // ******************************
  // Buffer guard and key selection
  // ******************************
  assign rx_buffer_guard       = guard_bit;
  assign standalone_key_choice = sakey_bit;
  assign transmit_key_choice   = txkey_bit;
  assign receive_key_choice    = rxkey_bit;
  // Stand-alone work overrides the link direction
  assign key_select = op_standalone ? standalone_key_choice :
                      dir_is_tx     ? transmit_key_choice : receive_key_choice;

  // ******************************
  // Tag length
  // ******************************
  isc_tag_decode u_tag (
    .tag_code     (tag_code),
    .tag_bytes    (tag_bytes),
    .tag_code_bad (tag_code_bad)
  );

  // ******************************
  // Clear prefix lengths
  // ******************************
  logic        inline_op;
  logic [6:0]  dir_prefix;
  logic        ctr_prefix_on;
  logic        cbc_prefix_on;
  logic        ccm_prefix_on;

  // Prefix lengths apply per mode and never to stand-alone operations
  assign inline_op       = !op_standalone;
  assign dir_prefix      = dir_is_tx ? tx_prefix : rx_prefix;
  assign ctr_prefix_on   = inline_op && mode_ctr;
  assign cbc_prefix_on   = inline_op && mode_cbcmac;
  assign ccm_prefix_on   = inline_op && mode_ccm;
  assign cipher_skip_len = gate_prefix(ctr_prefix_on, dir_prefix);
  assign auth_skip_len   = gate_prefix(cbc_prefix_on, dir_prefix);
  assign auth_only_len   = gate_prefix(ccm_prefix_on, dir_prefix);

  // ******************************
  // CBC-MAC first byte
  // ******************************
  logic [7:0]  tx_prefix_wide;
  logic [7:0]  tx_auth_len;
  logic [7:0]  rx_auth_len;

  // Only plain CBC-MAC uses the length-first form; CCM builds its own header
  assign mac_first_is_len = mode_cbcmac && len_first_bit;
  // Transmit length wraps modulo 256 when the prefix plus the two-byte trailer exceeds the frame
  assign tx_prefix_wide   = {1'b0, tx_prefix};
  assign tx_auth_len      = frame_len - tx_prefix_wide - isc_pkg::LEN_TRAILER;
  assign rx_auth_len      = {1'b0, rx_prefix};
  assign mac_first_len    = dir_is_tx ? tx_auth_len : rx_auth_len;

endmodule : isc_config
`default_nettype wire

// ### src/isc_pkg.sv
package isc_pkg;

  // ******************************
  // Register addresses
  // ******************************
  localparam logic [5:0] ADDR_SEC_PRIMARY = 6'h19;
  localparam logic [5:0] ADDR_SEC_LENGTH  = 6'h1A;

  // ******************************
  // Primary register fields
  // ******************************
  localparam int GUARD_BIT   = 9;
  localparam int HEAD_BIT    = 8;
  localparam int SAKEY_BIT   = 7;
  localparam int TXKEY_BIT   = 6;
  localparam int RXKEY_BIT   = 5;
  localparam int TAG_LSB     = 2;
  localparam int MODE_LSB    = 0;
  localparam logic [15:0] PRIMARY_WMASK = 16'h03FF;
  localparam logic [15:0] PRIMARY_RESET = 16'h03C4;

  // ******************************
  // Length register fields
  // ******************************
  localparam int TXL_LSB = 8;
  localparam int RXL_LSB = 0;
  localparam logic [15:0] LENGTH_WMASK = 16'h7F7F;
  localparam logic [15:0] LENGTH_RESET = 16'h0000;

  localparam logic [7:0] LEN_TRAILER = 8'h02;

  typedef enum logic [1:0] {
    ISC_MODE_OFF,
    ISC_MODE_CBCMAC,
    ISC_MODE_CTR,
    ISC_MODE_CCM
  } isc_mode_t;

endpackage : isc_pkg

// ### src/isc_tag_decode.sv
`timescale 1ns/1ps
`default_nettype none
module isc_tag_decode (
  // Code in
  input  wire logic [2:0] tag_code,
  // Decoded length
  output logic      [4:0] tag_bytes,
  output logic            tag_code_bad
);

  // Tag length M = 2*code + 2
  assign tag_bytes    = {1'b0, tag_code, 1'b0} + 5'h02;
  assign tag_code_bad = (tag_code == 3'h0);

endmodule : isc_tag_decode
`default_nettype wire

// ### bench/isc_config_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module isc_config_asserts (
  // Clock, reset, register port and context
  input wire logic        clk_sys, rst_n, reg_wr, dir_is_tx, op_standalone,
  input wire logic [5:0]  reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  // Decoded view
  input wire logic        rx_buffer_guard, mode_cbcmac, mode_ctr, key_select, mac_first_is_len,
  input wire logic        standalone_key_choice, transmit_key_choice, receive_key_choice,
  input wire logic [1:0]  inline_cipher_mode,
  input wire logic [4:0]  tag_bytes,
  input wire logic [6:0]  cipher_skip_len,
  input wire logic [7:0]  mac_first_len
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence wr_p; reg_wr && reg_addr == 6'h19; endsequence
  sequence wr_l; reg_wr && reg_addr == 6'h1A && !dir_is_tx; endsequence
  fields_a: assert property (wr_p |=> {rx_buffer_guard, standalone_key_choice,
    transmit_key_choice, receive_key_choice, inline_cipher_mode} ==
    {$past(reg_wdata[9]), $past(reg_wdata[7:5]), $past(reg_wdata[1:0])}) else $error("fields");
  tag_len_a: assert property (wr_p |=> tag_bytes == {$past(reg_wdata[4:2]), 1'b0} + 5'h02)
    else $error("tag length");
  mode_dec_a: assert property (mode_ctr == (inline_cipher_mode == 2'h2)
    && mode_cbcmac == (inline_cipher_mode == 2'h1)) else $error("mode decode");
  key_sel_a: assert property (key_select == (op_standalone ? standalone_key_choice :
    dir_is_tx ? transmit_key_choice : receive_key_choice)) else $error("key select");
  skip_a: assert property (cipher_skip_len != 7'h00 |-> mode_ctr && !op_standalone)
    else $error("skip length");
  first_len_a: assert property (wr_l ##1 !dir_is_tx |->
    mac_first_len == {1'b0, $past(reg_wdata[6:0])}) else $error("first length");
  head_sel_a: assert property (mac_first_is_len |-> mode_cbcmac) else $error("head");
  unmapped_a: assert property (!(reg_addr inside {6'h19, 6'h1A}) |-> reg_rdata == 16'h0000)
    else $error("unmapped read");
endmodule : isc_config_asserts
bind isc_config isc_config_asserts u_isc_config_asserts (.*);
`default_nettype wire

// ### bench/isc_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module isc_config_tb_top;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, dir_is_tx = 1'b0, op_standalone = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [7:0] frame_len = 8'h10, mac_first_len;
  logic rx_buffer_guard, sec_enabled, mode_cbcmac, mode_ctr, mode_ccm, key_select, tag_code_bad;
  logic standalone_key_choice, transmit_key_choice, receive_key_choice, mac_first_is_len;
  isc_pkg::isc_mode_t inline_cipher_mode;
  logic [4:0] tag_bytes;
  logic [6:0] cipher_skip_len, auth_skip_len, auth_only_len, p;
  int n_fail = 0, tests_run = 0, cyc = 0;
  isc_config u_isc_config (.*);
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 2000) begin
    n_fail++;
    close_out;
  end
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    #1 chk("rdata", reg_rdata, exp);
  endtask : rd
  task automatic t_reset;
    rd(6'h19, 16'h03C4);
    rd(6'h1A, 16'h0000);
    chk("keys", {standalone_key_choice, transmit_key_choice, receive_key_choice}, 3'b110);
    chk("guard", rx_buffer_guard, 1'b1);
    chk("rst tag", {tag_bytes, inline_cipher_mode}, {5'h04, 2'h0});
  endtask : t_reset
  task automatic t_modes;
    for (int c = 0; c < 32; c++) begin
      wr(6'h19, 16'(c));
      chk("mode", {mode_ccm, mode_ctr, mode_cbcmac, sec_enabled}, 24'(c % 4 ? 1 << c % 4 | 1 : 0));
      chk("tag", {tag_code_bad, tag_bytes}, {c / 4 == 0, 5'(c / 4 * 2 + 2)});
      chk("data first", mac_first_is_len, 1'b0);
    end
  endtask : t_modes
  task automatic t_rsvd;
    wr(6'h19, 16'hFFFF);
    rd(6'h19, 16'h03FF);
    wr(6'h1A, 16'hFFFF);
    rd(6'h1A, 16'h7F7F);
    wr(6'h3F, 16'h1234);
    rd(6'h3F, 16'h0000);
    rd(6'h19, 16'h03FF);
  endtask : t_rsvd
  task automatic t_prefix;
    wr(6'h1A, 16'h2305);
    for (int m = 1; m < 4; m++) for (int k = 0; k < 4; k++) begin
      wr(6'h19, 16'h0120 | 16'(m));
      {op_standalone, dir_is_tx} = 2'(k);
      p = op_standalone ? 7'h00 : dir_is_tx ? 7'h23 : 7'h05;
      #1 chk("skip", {cipher_skip_len, auth_skip_len, auth_only_len}, 24'(p) << 7 * (m % 3));
      chk("key", key_select, 24'(k == 0));
      chk("first", {mac_first_is_len, mac_first_len}, {m == 1, dir_is_tx ? 8'hEB : 8'h05});
    end
  endtask : t_prefix
  task automatic close_out;
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset;
    t_modes;
    t_rsvd;
    t_prefix;
    close_out;
  end
endmodule : isc_config_tb_top
`default_nettype wire
